// *** rtl/sensor_defs.svh ***
// constants of the sensor bus front-end: codes, offsets, limits, reset values
`ifndef SENSOR_DEFS_SVH
`define SENSOR_DEFS_SVH
// ----------------------------------------
// link codes
// ----------------------------------------
`define SLAVE_ADDR_DEFAULT 8'h2e
`define FC_READ_HOLD       8'h03
`define FC_READ_INPUT      8'h04
`define FC_WRITE_MULTI     8'h10
`define EXC_FLAG           8'h80
`define EXC_BAD_FUNC       8'h01
`define EXC_BAD_ADDR       8'h02
`define EXC_BAD_VALUE      8'h03
`define CRC_INIT           16'hffff
`define CRC_POLY           16'ha001
// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_TEMP_C         16'h03ea
`define REG_TEMP_F         16'h03ec
`define REG_TEMP_K         16'h03f0
`define REG_HUMID          16'h03fc
`define REG_TEMP_INT       16'h0fa1
`define REG_HUMID_INT      16'h0faa
`define REG_STATUS         16'h0259
`define MAP_WIN_FIRST      16'h0bb8
`define MAP_WIN_LAST       16'h0bcb
`define MAP_CFG_FIRST      16'h1770
`define MAP_ENTRIES        16'h000a
`define MAX_READ_QTY       16'h0020
// ----------------------------------------
// values and reset values
// ----------------------------------------
`define UNASSIGNED_WORD    16'hffff
`define FLOAT_NAN          32'h7fc00000
`define INT_INVALID        16'h8000
`define STATUS_RESET       16'h0000
`define TEMP_C_LOW         32'hc1f00000
`define TEMP_C_HIGH        32'h42700000
`define TEMP_F_LOW         32'hc1b00000
`define TEMP_F_HIGH        32'h430c0000
`define TEMP_K_LOW         32'h43732666
`define TEMP_K_HIGH        32'h43a69333
`define HUMID_LOW          32'h00000000
`define HUMID_HIGH         32'h42c80000
`define TEMP_INT_LOW       16'hf448
`define TEMP_INT_HIGH      16'h1770
`define HUMID_INT_LOW      16'h0000
`define HUMID_INT_HIGH     16'h2710
// ----------------------------------------
// status word bit positions
// ----------------------------------------
`define ST_TEMP_LOW        0
`define ST_TEMP_HIGH       1
`define ST_TEMP_INF        2
`define ST_HUMID_LOW       3
`define ST_HUMID_HIGH      4
`define ST_HUMID_INF       5
`define ST_ELEMENT         9
`define ST_DISPLAY         11
`endif

// *** rtl/sensor_pkg.sv ***
// types shared by the sensor bus front-end
package sensor_pkg;
	typedef struct packed {
		logic [31:0] temp_c;
		logic [31:0] temp_f;
		logic [31:0] temp_k;
		logic [31:0] relative_humidity_value;
		logic [15:0] temp_int;
		logic [15:0] humid_int;
	} meas_type;

	typedef struct packed {
		logic display_fault;
		logic element_fault;
		logic humid_inf;
		logic humid_high;
		logic humid_low;
		logic temp_inf;
		logic temp_high;
		logic temp_low;
	} sensor_flags_type;

	// floats have bit 2 clear and index the float table with bits 1:0
	typedef enum logic [2:0] {
		src_temp_c    = 3'h0,
		src_temp_f    = 3'h1,
		src_temp_k    = 3'h2,
		src_humid     = 3'h3,
		src_temp_int  = 3'h4,
		src_humid_int = 3'h5,
		src_none      = 3'h7
	} src_type;

	typedef enum logic [2:0] {
		st_idle   = 3'h0,
		st_recv   = 3'h1,
		st_commit = 3'h3,
		st_head   = 3'h2,
		st_fetch  = 3'h6,
		st_wait   = 3'h7,
		st_data   = 3'h5,
		st_crc    = 3'h4
	} state_type;

	typedef enum logic [1:0] {
		resp_read  = 2'h0,
		resp_write = 2'h1,
		resp_exc   = 2'h2
	} resp_type;
endpackage

// *** rtl/map_slot_mem.sv ***
// source table of the custom map, one entry per pair of map registers
`timescale 1ns/1ns
`default_nettype none
`include "sensor_defs.svh"
module map_slot_mem import sensor_pkg::*; (
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	// write port
	input  wire logic       wr_en,
	input  wire logic [3:0] wr_idx,
	input  wire src_type    wr_src,
	// read port
	input  wire logic [3:0] rd_idx,
	output src_type         rd_src
);
	src_type slot_reg [10];

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			for (int i = 0; i < 10; i++) begin
				slot_reg[i] <= src_none;
			end
		end else if (wr_en && ({12'h000, wr_idx} < `MAP_ENTRIES)) begin
			slot_reg[wr_idx] <= wr_src;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rd_src <= src_none;
		end else begin
			rd_src <= ({12'h000, rd_idx} < `MAP_ENTRIES) ? slot_reg[rd_idx] : src_none;
		end
	end
endmodule
`default_nettype wire

// *** rtl/modbus_sensor_register_access.sv ***
// register-access front-end of the room sensor: frame decode, map and replies
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ns
`default_nettype none
`include "sensor_defs.svh"
module modbus_sensor_register_access import sensor_pkg::*; #(
	parameter logic [7:0] SLAVE_ADDR = `SLAVE_ADDR_DEFAULT
) (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	// received bytes, frame gap marked by the line receiver
	input  wire logic              rx_byte_valid,
	input  wire logic [7:0]        rx_byte,
	input  wire logic              rx_frame_end,
	// reply bytes
	output logic                   tx_byte_valid,
	output logic [7:0]             tx_byte,
	input  wire logic              tx_byte_ready,
	// measurements and condition flags
	input  wire meas_type          meas,
	input  wire sensor_flags_type  flags,
	// building-automation object view
	output logic [3:0][31:0]       bac_present_value,
	output logic                   bac_reliability_no_sensor,
	output logic                   bac_event_state_fault
);
	// ----------------------------------------
	// measured values as served
	// ----------------------------------------
	logic              serious;
	logic [3:0][31:0]  raw_f;
	logic [3:0][31:0]  low_f;
	logic [3:0][31:0]  high_f;
	logic [3:0]        under_f;
	logic [3:0]        over_f;
	logic [3:0][31:0]  eff_f;
	logic [15:0]       eff_ti;
	logic [15:0]       eff_hi;
	logic [15:0]       status_word;

	// a missing element is the one fault that voids every value
	assign serious = flags.element_fault;
	assign raw_f   = {meas.relative_humidity_value, meas.temp_k, meas.temp_f, meas.temp_c};
	assign low_f   = {`HUMID_LOW, `TEMP_K_LOW, `TEMP_F_LOW, `TEMP_C_LOW};
	assign high_f  = {`HUMID_HIGH, `TEMP_K_HIGH, `TEMP_F_HIGH, `TEMP_C_HIGH};
	assign under_f = {flags.humid_low, {3{flags.temp_low}}};
	assign over_f  = {flags.humid_high, {3{flags.temp_high}}};

	for (genvar g = 0; g < 4; g++) begin : g_float
		assign eff_f[g] = serious ? `FLOAT_NAN :
			over_f[g] ? high_f[g] :
			under_f[g] ? low_f[g] : raw_f[g];
	end

	assign eff_ti = serious ? `INT_INVALID :
		flags.temp_high ? `TEMP_INT_HIGH :
		flags.temp_low ? `TEMP_INT_LOW : meas.temp_int;
	assign eff_hi = serious ? `INT_INVALID :
		flags.humid_high ? `HUMID_INT_HIGH :
		flags.humid_low ? `HUMID_INT_LOW : meas.humid_int;

	always_comb begin
		status_word                 = `STATUS_RESET;
		status_word[`ST_TEMP_LOW]   = flags.temp_low;
		status_word[`ST_TEMP_HIGH]  = flags.temp_high;
		status_word[`ST_TEMP_INF]   = flags.temp_inf;
		status_word[`ST_HUMID_LOW]  = flags.humid_low;
		status_word[`ST_HUMID_HIGH] = flags.humid_high;
		status_word[`ST_HUMID_INF]  = flags.humid_inf;
		status_word[`ST_ELEMENT]    = flags.element_fault;
		status_word[`ST_DISPLAY]    = flags.display_fault;
	end

	// ----------------------------------------
	// decoding helpers
	// ----------------------------------------
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic src_type addr_src(input logic [15:0] a);
		case (a)
			`REG_TEMP_C, `REG_TEMP_C + 16'h0001: addr_src = src_temp_c;
			`REG_TEMP_F, `REG_TEMP_F + 16'h0001: addr_src = src_temp_f;
			`REG_TEMP_K, `REG_TEMP_K + 16'h0001: addr_src = src_temp_k;
			`REG_HUMID, `REG_HUMID + 16'h0001:   addr_src = src_humid;
			`REG_TEMP_INT:                       addr_src = src_temp_int;
			`REG_HUMID_INT:                      addr_src = src_humid_int;
			default:                             addr_src = src_none;
		endcase
	endfunction

	function automatic logic in_win(input logic [15:0] a);
		return (a >= `MAP_WIN_FIRST) && (a <= `MAP_WIN_LAST);
	endfunction

	function automatic logic known(input logic [15:0] a);
		return in_win(a) || (a == `REG_STATUS) || (addr_src(a) != src_none);
	endfunction

	// second half of a float is its high word; an integer has no second half
	function automatic logic [15:0] src_word(input src_type s, input logic h);
		if (!s[2]) begin
			return h ? eff_f[s[1:0]][31:16] : eff_f[s[1:0]][15:0];
		end else if (s == src_temp_int && !h) begin
			return eff_ti;
		end else if (s == src_humid_int && !h) begin
			return eff_hi;
		end
		return `UNASSIGNED_WORD;
	endfunction

	// ----------------------------------------
	// frame state
	// ----------------------------------------
	state_type    state_reg;
	resp_type     resp_reg;
	logic [7:0]   rx_cnt_reg;
	logic [15:0]  rx_crc_reg;
	logic [7:0]   addr_reg;
	logic [7:0]   fc_reg;
	logic [15:0]  start_reg;
	logic [15:0]  qty_reg;
	logic [7:0]   bcnt_reg;
	logic [7:0]   data_hi_reg;
	src_type      stage_reg [10];
	logic [7:0]   exc_reg;
	logic [3:0]   idx_reg;
	logic [15:0]  cur_addr_reg;
	logic [15:0]  last_addr_reg;
	logic [15:0]  word_reg;
	logic [15:0]  tx_crc_reg;

	logic         rx_take;
	logic [7:0]   rx_idx;
	logic [15:0]  rx_crc_base;
	logic [7:0]   data_idx;
	src_type      cfg_src;
	logic         frame_ok;
	logic         is_read;
	logic         is_write;
	logic         read_qty_ok;
	logic         read_addr_ok;
	logic [15:0]  cfg_off;
	logic         write_qty_ok;
	logic         write_addr_ok;
	logic [15:0]  slot;
	src_type      rd_src;
	src_type      cur_src;
	logic [15:0]  word_val;
	logic [7:0]   head_byte;
	logic [3:0]   head_last;
	logic         load_ok;
	logic         emit_now;
	logic [7:0]   emit_byte;

	// bytes are only taken while not replying: the line is half duplex
	assign rx_take     = rx_byte_valid && (state_reg == st_idle || state_reg == st_recv);
	assign rx_idx      = (state_reg == st_idle) ? 8'h00 : rx_cnt_reg;
	assign rx_crc_base = (state_reg == st_idle) ? `CRC_INIT : rx_crc_reg;
	assign data_idx    = rx_idx - 8'h07;
	assign cfg_src     = addr_src({data_hi_reg, rx_byte});

	// a crc run over the whole frame, crc included, ends at zero
	assign frame_ok     = (rx_crc_reg == 16'h0000) && (rx_cnt_reg >= 8'h04)
		&& (addr_reg == SLAVE_ADDR);
	assign is_read      = (fc_reg == `FC_READ_HOLD) || (fc_reg == `FC_READ_INPUT);
	assign is_write     = fc_reg == `FC_WRITE_MULTI;
	assign read_qty_ok  = (qty_reg != 16'h0000) && (qty_reg <= `MAX_READ_QTY)
		&& (rx_cnt_reg == 8'h08);
	assign read_addr_ok = known(start_reg) && known(start_reg + qty_reg - 16'h0001);
	assign cfg_off      = start_reg - `MAP_CFG_FIRST;
	assign write_qty_ok = (qty_reg != 16'h0000) && (qty_reg <= `MAP_ENTRIES)
		&& (bcnt_reg == {qty_reg[6:0], 1'b0}) && (rx_cnt_reg == bcnt_reg + 8'h09);
	assign write_addr_ok = (start_reg >= `MAP_CFG_FIRST)
		&& (cfg_off + qty_reg <= `MAP_ENTRIES);

	// map entry n covers map registers 2n and 2n+1
	assign slot     = cur_addr_reg - `MAP_WIN_FIRST;
	assign cur_src  = addr_src(cur_addr_reg);
	// a process, not an assign: src_word reads eff_f, which an assign would not track
	always_comb begin
		word_val = in_win(cur_addr_reg) ? src_word(rd_src, slot[0]) :
			(cur_addr_reg == `REG_STATUS) ? status_word :
			src_word(cur_src, cur_addr_reg[0] & ~cur_src[2]);
	end

	map_slot_mem u_map (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.wr_en   (state_reg == st_commit),
		.wr_idx  (cfg_off[3:0] + idx_reg),
		.wr_src  (stage_reg[idx_reg]),
		.rd_idx  (slot[4:1]),
		.rd_src  (rd_src)
	);

	// ----------------------------------------
	// reply bytes
	// ----------------------------------------
	always_comb begin
		case (idx_reg)
			4'h0:    head_byte = SLAVE_ADDR;
			4'h1:    head_byte = (resp_reg == resp_exc) ? (fc_reg | `EXC_FLAG) : fc_reg;
			4'h2:    head_byte = (resp_reg == resp_read) ? {qty_reg[6:0], 1'b0} :
				(resp_reg == resp_exc) ? exc_reg : start_reg[15:8];
			4'h3:    head_byte = start_reg[7:0];
			4'h4:    head_byte = qty_reg[15:8];
			default: head_byte = qty_reg[7:0];
		endcase
	end

	assign head_last = (resp_reg == resp_write) ? 4'h5 : 4'h2;
	assign load_ok   = !tx_byte_valid || tx_byte_ready;
	assign emit_now  = load_ok && (state_reg == st_head || state_reg == st_data
		|| state_reg == st_crc);
	assign emit_byte = (state_reg == st_head) ? head_byte :
		(state_reg == st_data) ? (idx_reg[0] ? word_reg[7:0] : word_reg[15:8]) :
		(idx_reg[0] ? tx_crc_reg[15:8] : tx_crc_reg[7:0]);

	// ----------------------------------------
	// receive capture
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rx_cnt_reg <= 8'h00;
			rx_crc_reg <= `CRC_INIT;
		end else if (rx_take) begin
			rx_cnt_reg <= (rx_idx == 8'hff) ? rx_idx : rx_idx + 8'h01;
			rx_crc_reg <= crc_step(rx_crc_base, rx_byte);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rx_take) begin
			case (rx_idx)
				8'h00:   addr_reg <= rx_byte;
				8'h01:   fc_reg <= rx_byte;
				8'h02:   start_reg[15:8] <= rx_byte;
				8'h03:   start_reg[7:0] <= rx_byte;
				8'h04:   qty_reg[15:8] <= rx_byte;
				8'h05:   qty_reg[7:0] <= rx_byte;
				8'h06:   bcnt_reg <= rx_byte;
				default: begin
					if (!data_idx[0]) begin
						data_hi_reg <= rx_byte;
					end else if (data_idx < 8'h14) begin
						// only the first word of a float is a legal source
						stage_reg[data_idx[4:1]] <= (!cfg_src[2] && rx_byte[0]) ?
							src_none : cfg_src;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_reg <= st_idle;
			resp_reg  <= resp_read;
			exc_reg   <= 8'h00;
			idx_reg   <= 4'h0;
		end else begin
			case (state_reg)
				st_idle: begin
					if (rx_byte_valid) begin
						state_reg <= st_recv;
					end
				end
				st_recv: begin
					if (rx_frame_end) begin
						idx_reg       <= 4'h0;
						cur_addr_reg  <= start_reg;
						last_addr_reg <= start_reg + qty_reg - 16'h0001;
						state_reg     <= st_head;
						resp_reg      <= resp_exc;
						if (!frame_ok) begin
							state_reg <= st_idle;
						end else if (is_read) begin
							exc_reg <= read_qty_ok ? `EXC_BAD_ADDR : `EXC_BAD_VALUE;
							if (read_qty_ok && read_addr_ok) begin
								resp_reg <= resp_read;
							end
						end else if (is_write) begin
							exc_reg <= write_qty_ok ? `EXC_BAD_ADDR : `EXC_BAD_VALUE;
							if (write_qty_ok && write_addr_ok) begin
								resp_reg  <= resp_write;
								state_reg <= st_commit;
							end
						end else begin
							exc_reg <= `EXC_BAD_FUNC;
						end
					end
				end
				st_commit: begin
					idx_reg <= idx_reg + 4'h1;
					if ({12'h000, idx_reg} == qty_reg - 16'h0001) begin
						idx_reg   <= 4'h0;
						state_reg <= st_head;
					end
				end
				st_head: begin
					if (emit_now) begin
						idx_reg <= idx_reg + 4'h1;
						if (idx_reg == head_last) begin
							idx_reg   <= 4'h0;
							state_reg <= (resp_reg == resp_read) ? st_fetch : st_crc;
						end
					end
				end
				st_fetch: state_reg <= st_wait;
				st_wait: begin
					word_reg  <= word_val;
					state_reg <= st_data;
				end
				st_data: begin
					if (emit_now) begin
						idx_reg <= idx_reg ^ 4'h1;
						if (idx_reg[0]) begin
							cur_addr_reg <= cur_addr_reg + 16'h0001;
							// every register of the range is sent, unassigned ones too
							state_reg <= (cur_addr_reg == last_addr_reg) ?
								st_crc : st_fetch;
						end
					end
				end
				st_crc: begin
					if (emit_now) begin
						idx_reg <= idx_reg ^ 4'h1;
						if (idx_reg[0]) begin
							idx_reg   <= 4'h0;
							state_reg <= st_idle;
						end
					end
				end
				default: state_reg <= st_idle;
			endcase
		end
	end

	// ----------------------------------------
	// reply output stage
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			tx_byte_valid <= 1'b0;
			tx_byte       <= 8'h00;
			tx_crc_reg    <= `CRC_INIT;
		end else if (emit_now) begin
			tx_byte_valid <= 1'b1;
			tx_byte       <= emit_byte;
			if (state_reg != st_crc) begin
				tx_crc_reg <= crc_step(tx_crc_reg, emit_byte);
			end
		end else begin
			if (tx_byte_ready) begin
				tx_byte_valid <= 1'b0;
			end
			if (state_reg == st_recv) begin
				tx_crc_reg <= `CRC_INIT;
			end
		end
	end

	// ----------------------------------------
	// object view
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			bac_present_value         <= '0;
			bac_reliability_no_sensor <= 1'b0;
			bac_event_state_fault     <= 1'b0;
		end else begin
			bac_present_value         <= eff_f;
			bac_reliability_no_sensor <= serious;
			bac_event_state_fault     <= serious;
		end
	end
endmodule
`default_nettype wire

// *** tb/sensor_master_model.sv ***
// bus-master model: sends request frames and collects reply bytes
`timescale 1ns/1ns
`default_nettype none
module sensor_master_model (
	// clock
	input  wire logic       ref_clk,
	// request bytes
	output logic            rx_byte_valid,
	output logic [7:0]      rx_byte,
	output logic            rx_frame_end,
	// reply bytes
	input  wire logic       tx_byte_valid,
	input  wire logic [7:0] tx_byte,
	output logic            tx_byte_ready
);
	logic [7:0] got[$];
	logic       slow = 1'b0;
	initial begin
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
		rx_frame_end = 1'b0;
		tx_byte_ready = 1'b0;
	end
	// a stalling master accepts only every other cycle
	always @(negedge ref_clk) begin
		tx_byte_ready <= slow ? ~tx_byte_ready : 1'b1;
	end
	always @(posedge ref_clk) begin
		if (tx_byte_valid && tx_byte_ready) begin
			got.push_back(tx_byte);
		end
	end
	// one byte per pulse, then the frame gap
	task send(input logic [7:0] f[$]);
		got.delete();
		foreach (f[i]) begin
			@(negedge ref_clk);
			rx_byte_valid <= 1'b1;
			rx_byte <= f[i];
			@(negedge ref_clk);
			rx_byte_valid <= 1'b0;
			// idle line shows inverse data so stale bytes never look valid
			rx_byte <= ~f[i];
		end
		@(negedge ref_clk);
		rx_frame_end <= 1'b1;
		@(negedge ref_clk);
		rx_frame_end <= 1'b0;
	endtask
endmodule
`default_nettype wire

// *** tb/modbus_sensor_register_access_chk.sv ***
// port assertions of the sensor bus front-end
`timescale 1ns/1ns
`default_nettype none
`include "sensor_defs.svh"
module modbus_sensor_register_access_chk import sensor_pkg::*; #(
	parameter logic [7:0] SLAVE_ADDR = `SLAVE_ADDR_DEFAULT
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	// link
	input  wire logic             rx_byte_valid,
	input  wire logic [7:0]       rx_byte,
	input  wire logic             rx_frame_end,
	input  wire logic             tx_byte_valid,
	input  wire logic [7:0]       tx_byte,
	input  wire logic             tx_byte_ready,
	// sensor side
	input  wire meas_type         meas,
	input  wire sensor_flags_type flags,
	input  wire logic [3:0][31:0] bac_present_value,
	input  wire logic             bac_reliability_no_sensor,
	input  wire logic             bac_event_state_fault
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	property p_hold;
		tx_byte_valid && !tx_byte_ready |=> tx_byte_valid && $stable(tx_byte);
	endproperty
	a_hold: assert property (p_hold) else $error("reply byte moved early");
	property p_quiet;
		(rx_byte_valid || rx_frame_end) |=> !tx_byte_valid;
	endproperty
	a_quiet: assert property (p_quiet) else $error("reply during receive");
	property p_first;
		rx_frame_end ##2 tx_byte_valid |-> tx_byte == SLAVE_ADDR;
	endproperty
	a_first: assert property (p_first) else $error("reply not from own address");
	property p_rel;
		$past(rst_b) && $past(rst_b, 2) |->
			bac_reliability_no_sensor == $past(flags.element_fault);
	endproperty
	a_rel: assert property (p_rel) else $error("reliability wrong");
	property p_evt;
		$past(rst_b) && $past(rst_b, 2) |->
			bac_event_state_fault == $past(flags.element_fault);
	endproperty
	a_evt: assert property (p_evt) else $error("event state wrong");
	property p_nan;
		$past(rst_b) && $past(rst_b, 2) && $past(flags.element_fault) |->
			bac_present_value == {4{`FLOAT_NAN}};
	endproperty
	a_nan: assert property (p_nan) else $error("object value not nan");
	property p_clampt;
		$past(rst_b) && $past(rst_b, 2) && $past(flags.temp_high)
			&& !$past(flags.element_fault) |->
			bac_present_value[0] == `TEMP_C_HIGH && bac_present_value[1] == `TEMP_F_HIGH;
	endproperty
	a_clampt: assert property (p_clampt) else $error("temperature not clamped");
	property p_clamph;
		$past(rst_b) && $past(rst_b, 2) && $past(flags.humid_low)
			&& !$past(flags.element_fault) |-> bac_present_value[3] == `HUMID_LOW;
	endproperty
	a_clamph: assert property (p_clamph) else $error("humidity not clamped");
endmodule
bind modbus_sensor_register_access modbus_sensor_register_access_chk #(
	.SLAVE_ADDR(SLAVE_ADDR)
) modbus_sensor_register_access_chk_i (
	.ref_clk(ref_clk), .rst_b(rst_b), .rx_byte_valid(rx_byte_valid),
	.rx_byte(rx_byte), .rx_frame_end(rx_frame_end), .tx_byte_valid(tx_byte_valid),
	.tx_byte(tx_byte), .tx_byte_ready(tx_byte_ready), .meas(meas), .flags(flags),
	.bac_present_value(bac_present_value),
	.bac_reliability_no_sensor(bac_reliability_no_sensor),
	.bac_event_state_fault(bac_event_state_fault)
);
`default_nettype wire

// *** tb/modbus_sensor_register_access_test.sv ***
// self-checking bench of the sensor bus front-end
`timescale 1ns/1ns
`default_nettype none
`include "sensor_defs.svh"
module modbus_sensor_register_access_test import sensor_pkg::*; ;
	typedef logic [7:0] bq_type[$];
	typedef logic [15:0] wq_type[$];
	localparam logic [7:0] ADDR = `SLAVE_ADDR_DEFAULT;
	logic             ref_clk = 1'b0;
	logic             rst_b = 1'b0;
	logic             rx_byte_valid, rx_frame_end, tx_byte_valid, tx_byte_ready;
	logic [7:0]       rx_byte, tx_byte;
	meas_type         meas;
	sensor_flags_type flags;
	logic [3:0][31:0] bac_present_value;
	logic             bac_reliability_no_sensor, bac_event_state_fault;
	int               error_cnt = 0;
	int               comparisons = 0;
	always #20 ref_clk = ~ref_clk;
	modbus_sensor_register_access #(.SLAVE_ADDR(ADDR)) modbus_sensor_register_access_i (
		.ref_clk(ref_clk), .rst_b(rst_b), .rx_byte_valid(rx_byte_valid),
		.rx_byte(rx_byte), .rx_frame_end(rx_frame_end), .tx_byte_valid(tx_byte_valid),
		.tx_byte(tx_byte), .tx_byte_ready(tx_byte_ready), .meas(meas), .flags(flags),
		.bac_present_value(bac_present_value),
		.bac_reliability_no_sensor(bac_reliability_no_sensor),
		.bac_event_state_fault(bac_event_state_fault)
	);
	sensor_master_model sensor_master_model_i (
		.ref_clk(ref_clk), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
		.rx_frame_end(rx_frame_end), .tx_byte_valid(tx_byte_valid), .tx_byte(tx_byte),
		.tx_byte_ready(tx_byte_ready)
	);
	// ------
	// helpers
	// ------
	function automatic logic [15:0] crc(input bq_type b);
		logic [15:0] c;
		c = `CRC_INIT;
		foreach (b[i]) begin
			c ^= {8'h00, b[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		if (error_cnt == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// dropped frames expect an empty reply; the wait is bounded either way
	task xfer(input bq_type req, input bq_type exp, input bit bad);
		logic [15:0] c;
		int          n;
		c = crc(req);
		req.push_back(c[7:0]);
		req.push_back(c[15:8]);
		if (bad) req[$] ^= 8'h01;
		if (exp.size() > 0) begin
			c = crc(exp);
			exp.push_back(c[7:0]);
			exp.push_back(c[15:8]);
		end
		sensor_master_model_i.send(req);
		n = 0;
		while (sensor_master_model_i.got.size() < exp.size() && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
		repeat (20) @(posedge ref_clk);
		check(32'(sensor_master_model_i.got.size()), 32'(exp.size()));
		foreach (exp[i]) begin
			if (i < sensor_master_model_i.got.size()) begin
				check(32'(sensor_master_model_i.got[i]), 32'(exp[i]));
			end
		end
		@(negedge ref_clk);
	endtask
	task rd(input logic [7:0] sa, input logic [15:0] a, input wq_type w, input bit bad = 1'b0);
		bq_type req;
		bq_type exp;
		req = {sa, `FC_READ_HOLD, a[15:8], a[7:0], 8'h00, 8'(w.size())};
		exp = {ADDR, `FC_READ_HOLD, 8'(2 * w.size())};
		foreach (w[i]) begin
			exp.push_back(w[i][15:8]);
			exp.push_back(w[i][7:0]);
		end
		if (sa !== ADDR || bad) exp.delete();
		xfer(req, exp, bad);
	endtask
	task wr(input logic [15:0] a, input wq_type w);
		bq_type req;
		req = {ADDR, `FC_WRITE_MULTI, a[15:8], a[7:0], 8'h00, 8'(w.size()), 8'(2 * w.size())};
		foreach (w[i]) begin
			req.push_back(w[i][15:8]);
			req.push_back(w[i][7:0]);
		end
		xfer(req, req[0:5], 1'b0);
	endtask
	// ------
	// tests
	// ------
	initial begin
		meas = {32'h41bb851f, 32'h42743d71, 32'h43966b85, 32'h42560a3d, 16'h0928, 16'h1194};
		flags = '0;
		repeat (10) @(negedge ref_clk);
		rst_b = 1'b1;
		rd(ADDR, `REG_TEMP_C, {16'h851f, 16'h41bb});
		xfer({ADDR, `FC_READ_INPUT, 8'h03, 8'hea, 8'h00, 8'h02},
			{ADDR, `FC_READ_INPUT, 8'h04, 8'h85, 8'h1f, 8'h41, 8'hbb}, 1'b0);
		xfer({ADDR, `FC_READ_HOLD, 8'h00, 8'h00, 8'h00, 8'h01},
			{ADDR, `FC_READ_HOLD | `EXC_FLAG, `EXC_BAD_ADDR}, 1'b0);
		rd(8'h2d, `REG_TEMP_C, {16'h851f, 16'h41bb});
		rd(ADDR, `REG_TEMP_C, {16'h851f, 16'h41bb}, 1'b1);
		rd(ADDR, `MAP_WIN_FIRST, {16'hffff, 16'hffff});
		wr(`MAP_CFG_FIRST, {`REG_HUMID, `REG_TEMP_C, `REG_TEMP_INT});
		sensor_master_model_i.slow = 1'b1;
		rd(ADDR, `MAP_WIN_FIRST, {16'h0a3d, 16'h4256, 16'h851f, 16'h41bb,
			16'h0928, 16'hffff});
		sensor_master_model_i.slow = 1'b0;
		// a mid-run reset must leave map entry 0, the only one read back here, unassigned again
		rst_b = 1'b0;
		repeat (2) @(negedge ref_clk);
		rst_b = 1'b1;
		rd(ADDR, `MAP_WIN_FIRST, {16'hffff, 16'hffff});
		flags.temp_high = 1'b1;
		flags.humid_low = 1'b1;
		rd(ADDR, `REG_STATUS, {16'h000a});
		rd(ADDR, `REG_TEMP_C, {16'h0000, 16'h4270});
		rd(ADDR, `REG_TEMP_INT, {`TEMP_INT_HIGH});
		check(bac_present_value[3], `HUMID_LOW);
		flags = '0;
		flags.element_fault = 1'b1;
		rd(ADDR, `REG_STATUS, {16'h0200});
		rd(ADDR, `REG_TEMP_C, {16'h0000, 16'h7fc0});
		rd(ADDR, `REG_TEMP_INT, {`INT_INVALID});
		check(bac_present_value[0], `FLOAT_NAN);
		check(32'(bac_reliability_no_sensor), 32'h1);
		check(32'(bac_event_state_fault), 32'h1);
		flags = '0;
		repeat (3) @(negedge ref_clk);
		check(32'(bac_event_state_fault), 32'h0);
		print_verdict;
	end
	// whole run is well under 10000 cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		print_verdict;
	end
endmodule
`default_nettype wire
